// File: logic/sspm_cfg.svh
`ifndef SSPM_CFG_SVH
`define SSPM_CFG_SVH
// Register indices on the plain register port
`define SSPM_OFS_STAT 2'h0
`define SSPM_OFS_CON1 2'h1
`define SSPM_OFS_CON2 2'h2
`define SSPM_OFS_BUF 2'h3
// Status and control register fields
`define SSPM_ST_EN 15
`define SSPM_ST_SIDL 13
`define SSPM_ST_ROV 6
`define SSPM_ST_TBF 1
`define SSPM_ST_RBF 0
// Control register one fields
`define SSPM_C1_SHIFT_CLOCK_DISABLE 12
`define SSPM_C1_SERIAL_OUT_DISABLE 11
`define SSPM_C1_W16 10
`define SSPM_C1_SMP 9
`define SSPM_C1_CKE 8
`define SSPM_C1_SLAVE_SELECT_USE 7
`define SSPM_C1_CKP 6
`define SSPM_C1_MST 5
`define SSPM_C1_WMASK 16'h1fff
// Control register two fields
`define SSPM_C2_FRM 15
`define SSPM_C2_FSD 14
`define SSPM_C2_FPOL 13
`define SSPM_C2_FDLY 1
`define SSPM_C2_WMASK 16'he002
`define SSPM_RST_VAL 16'h0000
`endif

// File: logic/sspm_pkg.sv
`default_nettype none
package sspm_pkg;
    typedef enum logic [2:0] {
        SSPM_IDLE = 3'b001,
        SSPM_SYNC = 3'b010,
        SSPM_XFER = 3'b100
    } sspm_state_t;
    // Decoded control fields
    typedef struct packed {
        logic en;
        logic sidl;
        logic dis_sck;
        logic dis_sdo;
        logic w16;
        logic sample_phase_sel;
        logic cke;
        logic slave_select_use;
        logic clock_polarity;
        logic mst;
        logic [2:0] spre;
        logic [1:0] ppre;
        logic frm;
        logic fsd;
        logic fpol;
        logic fdly;
    } sspm_cfg_t;
endpackage : sspm_pkg
`default_nettype wire

// File: logic/sspm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sspm_cfg.svh"
module sspm_core (
    // System clock domain
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic idle_mode,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Shift clock pin, its input is the slave link clock
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe,
    // Serial data pins
    input wire logic serial_in_pin,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    // Slave select or frame sync pin
    input wire logic slave_select_n_i,
    output logic slave_select_n_o,
    output logic slave_select_n_oe
);
    function automatic logic word_msb(input logic [15:0] w, input logic w16);
        word_msb = w16 ? w[15] : w[7];
    endfunction : word_msb
    function automatic logic [15:0] word_mask(input logic [15:0] w,
                                             input logic w16);
        word_mask = w16 ? w : {8'h00, w[7:0]};
    endfunction : word_mask
    function automatic logic [9:0] half_period(input logic [1:0] pp,
                                               input logic [2:0] sp);
        logic [6:0] p;
        logic [3:0] s;
        p = 7'h01;
        case (pp)
            2'h0: p = 7'h40;
            2'h1: p = 7'h10;
            2'h2: p = 7'h04;
            default: p = 7'h01;
        endcase
        s = 4'h8 - {1'b0, sp};
        half_period = 10'({3'h0, p} * {6'h00, s});
    endfunction : half_period
    logic [15:0] stat_ff, con1_ff, con2_ff, nxt_stat, nxt_con1, nxt_con2;
    logic [15:0] tx_holding_ff, rx_holding_ff, nxt_tx_holding, nxt_rx_holding;
    logic [15:0] shift_reg_ff, nxt_shift_reg, slv_tx_ff, nxt_slv_tx;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [9:0] div_ff, nxt_div;
    logic [4:0] edge_ff, nxt_edge;
    logic slot_ff, nxt_slot, sck_ff, nxt_sck, msdo_ff, nxt_msdo;
    logic fsync_ff, nxt_fsync, sck_oe_ff, sdo_oe_ff, ss_oe_ff, buf_wr, buf_rd;
    logic [1:0] sdi_sync_ff, ss_sync_ff;
    logic [2:0] tgl_sync_ff;
    sspm_pkg::sspm_state_t st_ff, nxt_st;
    sspm_pkg::sspm_cfg_t cfg;
    logic cke_eff, run, tick, lead, is_samp, is_chg, last_edge;
    logic slv_done, sync_in;
    logic [15:0] ns;
    // Link domain
    logic [15:0] lk_shift_ff, lk_rx_ff, nxt_lk_shift, nxt_lk_rx, lk_src;
    logic [4:0] lk_cnt_ff, nxt_lk_cnt;
    logic lk_tgl_ff, nxt_lk_tgl, lk_sdo_ff, lk_clk, lk_sel, lk_go;
    always_comb begin
        cfg.en = stat_ff[`SSPM_ST_EN];
        cfg.sidl = stat_ff[`SSPM_ST_SIDL];
        cfg.dis_sck = con1_ff[`SSPM_C1_SHIFT_CLOCK_DISABLE];
        cfg.dis_sdo = con1_ff[`SSPM_C1_SERIAL_OUT_DISABLE];
        cfg.w16 = con1_ff[`SSPM_C1_W16];
        cfg.sample_phase_sel = con1_ff[`SSPM_C1_SMP];
        cfg.cke = con1_ff[`SSPM_C1_CKE];
        cfg.slave_select_use = con1_ff[`SSPM_C1_SLAVE_SELECT_USE];
        cfg.clock_polarity = con1_ff[`SSPM_C1_CKP];
        cfg.mst = con1_ff[`SSPM_C1_MST];
        cfg.spre = con1_ff[4:2];
        cfg.ppre = con1_ff[1:0];
        cfg.frm = con2_ff[`SSPM_C2_FRM];
        cfg.fsd = con2_ff[`SSPM_C2_FSD];
        cfg.fpol = con2_ff[`SSPM_C2_FPOL];
        cfg.fdly = con2_ff[`SSPM_C2_FDLY];
    end
    assign cke_eff = cfg.cke & ~cfg.frm;
    assign run = cfg.en & ~(cfg.sidl & idle_mode);
    assign slv_done = tgl_sync_ff[1] ^ tgl_sync_ff[2];
    assign buf_wr = reg_wr && (reg_addr == `SSPM_OFS_BUF);
    assign buf_rd = reg_rd && (reg_addr == `SSPM_OFS_BUF);
    assign sync_in = ss_sync_ff[1] ~^ cfg.fpol;
    assign tick = (st_ff != sspm_pkg::SSPM_IDLE) &&
                  (div_ff == half_period(cfg.ppre, cfg.spre) - 10'h001);
    assign lead = ~edge_ff[0];
    assign is_samp = cfg.sample_phase_sel ? ~lead : (lead == cke_eff);
    assign is_chg = lead != cke_eff;
    assign last_edge = edge_ff == (cfg.w16 ? 5'h1f : 5'h0f);
    assign ns = is_samp ? {shift_reg_ff[14:0], sdi_sync_ff[1]} : shift_reg_ff;

    always_comb begin
        nxt_stat = stat_ff;
        nxt_con1 = con1_ff;
        nxt_con2 = con2_ff;
        nxt_tx_holding = tx_holding_ff;
        nxt_rx_holding = rx_holding_ff;
        nxt_shift_reg = shift_reg_ff;
        nxt_slv_tx = slv_tx_ff;
        nxt_slot = slot_ff;
        nxt_st = st_ff;
        nxt_div = div_ff;
        nxt_edge = edge_ff;
        nxt_sck = sck_ff;
        nxt_msdo = msdo_ff;
        nxt_fsync = fsync_ff;
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `SSPM_OFS_STAT: nxt_rdata = stat_ff;
                `SSPM_OFS_CON1: nxt_rdata = con1_ff;
                `SSPM_OFS_CON2: nxt_rdata = con2_ff;
                default: begin
                    nxt_rdata = rx_holding_ff;
                    nxt_stat[`SSPM_ST_RBF] = 1'b0;
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                `SSPM_OFS_STAT: begin
                    nxt_stat[`SSPM_ST_EN] = reg_wdata[`SSPM_ST_EN];
                    nxt_stat[`SSPM_ST_SIDL] = reg_wdata[`SSPM_ST_SIDL];
                    if (!reg_wdata[`SSPM_ST_ROV])
                        nxt_stat[`SSPM_ST_ROV] = 1'b0;
                end
                `SSPM_OFS_CON1: nxt_con1 = reg_wdata & `SSPM_C1_WMASK;
                `SSPM_OFS_CON2: nxt_con2 = reg_wdata & `SSPM_C2_WMASK;
                default: begin
                    nxt_tx_holding = reg_wdata;
                    nxt_stat[`SSPM_ST_TBF] = 1'b1;
                end
            endcase
        end
        if (!cfg.en) begin
            nxt_st = sspm_pkg::SSPM_IDLE;
            nxt_slot = 1'b0;
            nxt_fsync = 1'b0;
        end
        // Slave: hand the waiting word to the link side
        if (cfg.en && !cfg.mst && stat_ff[`SSPM_ST_TBF] && !slot_ff) begin
            nxt_slv_tx = tx_holding_ff;
            nxt_slot = 1'b1;
            nxt_stat[`SSPM_ST_TBF] = buf_wr;
        end
        if (slv_done)
            nxt_slot = 1'b0;
        case (st_ff)
            sspm_pkg::SSPM_IDLE: begin
                nxt_sck = cfg.clock_polarity;
                nxt_div = 10'h000;
                nxt_edge = 5'h00;
                if (run && cfg.mst && stat_ff[`SSPM_ST_TBF] &&
                    (!cfg.frm || !cfg.fsd || sync_in)) begin
                    nxt_shift_reg = tx_holding_ff;
                    nxt_stat[`SSPM_ST_TBF] = buf_wr;
                    nxt_msdo = word_msb(tx_holding_ff, cfg.w16);
                    nxt_fsync = cfg.frm && !cfg.fsd;
                    nxt_st = (cfg.frm && !cfg.fsd && !cfg.fdly) ?
                             sspm_pkg::SSPM_SYNC : sspm_pkg::SSPM_XFER;
                end
            end
            sspm_pkg::SSPM_SYNC: begin
                if (run) begin
                    nxt_div = tick ? 10'h000 : div_ff + 10'h001;
                    if (tick) begin
                        nxt_edge = edge_ff + 5'h01;
                        if (edge_ff[0]) begin
                            nxt_edge = 5'h00;
                            nxt_fsync = 1'b0;
                            nxt_st = sspm_pkg::SSPM_XFER;
                        end
                    end
                end
            end
            sspm_pkg::SSPM_XFER: begin
                if (run) begin
                    nxt_div = tick ? 10'h000 : div_ff + 10'h001;
                    if (tick) begin
                        nxt_sck = ~sck_ff;
                        nxt_edge = edge_ff + 5'h01;
                        nxt_shift_reg = ns;
                        if (is_chg)
                            nxt_msdo = word_msb(ns, cfg.w16);
                        if (edge_ff == 5'h01)
                            nxt_fsync = 1'b0;
                        if (last_edge)
                            nxt_st = sspm_pkg::SSPM_IDLE;
                    end
                end
            end
            default: nxt_st = sspm_pkg::SSPM_IDLE;
        endcase
        // Completed word into the receive buffer, or dropped on overflow
        if ((st_ff == sspm_pkg::SSPM_XFER && run && tick && last_edge) ||
            slv_done) begin
            if (stat_ff[`SSPM_ST_RBF] && !buf_rd) begin
                nxt_stat[`SSPM_ST_ROV] = 1'b1;
            end else begin
                nxt_rx_holding = slv_done ? word_mask(lk_rx_ff, cfg.w16) :
                                 word_mask(ns, cfg.w16);
                nxt_stat[`SSPM_ST_RBF] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stat_ff <= `SSPM_RST_VAL;
            con1_ff <= `SSPM_RST_VAL;
            con2_ff <= `SSPM_RST_VAL;
            tx_holding_ff <= 16'h0000;
            rx_holding_ff <= 16'h0000;
            shift_reg_ff <= 16'h0000;
            slv_tx_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            slot_ff <= 1'b0;
            st_ff <= sspm_pkg::SSPM_IDLE;
            div_ff <= 10'h000;
            edge_ff <= 5'h00;
            sck_ff <= 1'b0;
            msdo_ff <= 1'b0;
            fsync_ff <= 1'b0;
            sck_oe_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            ss_oe_ff <= 1'b0;
            sdi_sync_ff <= 2'h0;
            ss_sync_ff <= 2'h3;
            tgl_sync_ff <= 3'h0;
        end else if (clk_en) begin
            stat_ff <= nxt_stat;
            con1_ff <= nxt_con1;
            con2_ff <= nxt_con2;
            tx_holding_ff <= nxt_tx_holding;
            rx_holding_ff <= nxt_rx_holding;
            shift_reg_ff <= nxt_shift_reg;
            slv_tx_ff <= nxt_slv_tx;
            rdata_ff <= nxt_rdata;
            slot_ff <= nxt_slot;
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            edge_ff <= nxt_edge;
            sck_ff <= nxt_sck;
            msdo_ff <= nxt_msdo;
            fsync_ff <= nxt_fsync;
            sck_oe_ff <= cfg.en & cfg.mst & ~cfg.dis_sck;
            sdo_oe_ff <= cfg.en & ~cfg.dis_sdo;
            ss_oe_ff <= cfg.en & cfg.mst & cfg.frm & ~cfg.fsd;
            sdi_sync_ff <= {sdi_sync_ff[0], serial_in_pin};
            ss_sync_ff <= {ss_sync_ff[0], slave_select_n_i};
            tgl_sync_ff <= {tgl_sync_ff[1:0], lk_tgl_ff};
        end
    end

    // Slave side: rising lk_clk is the sample edge of the pin clock
    assign lk_clk = shift_clock_pin_i ^ ~(cfg.clock_polarity ^ cke_eff);
    assign lk_sel = cfg.en & ~cfg.mst &
                    (cfg.frm | ~cfg.slave_select_use | ~slave_select_n_i);
    assign lk_go = (lk_cnt_ff != 5'h00) | ~cfg.frm |
                   (slave_select_n_i ~^ cfg.fpol);
    assign lk_src = (lk_cnt_ff == 5'h00) ? slv_tx_ff : lk_shift_ff;

    always_comb begin
        nxt_lk_shift = lk_shift_ff;
        nxt_lk_rx = lk_rx_ff;
        nxt_lk_cnt = lk_cnt_ff;
        nxt_lk_tgl = lk_tgl_ff;
        if (!lk_sel) begin
            nxt_lk_cnt = 5'h00;
        end else if (lk_go) begin
            nxt_lk_shift = {lk_src[14:0], serial_in_pin};
            nxt_lk_cnt = lk_cnt_ff + 5'h01;
            if (lk_cnt_ff == (cfg.w16 ? 5'h0f : 5'h07)) begin
                nxt_lk_cnt = 5'h00;
                nxt_lk_rx = nxt_lk_shift;
                nxt_lk_tgl = ~lk_tgl_ff;
            end
        end
    end

    always_ff @(posedge lk_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_shift_ff <= 16'h0000;
            lk_rx_ff <= 16'h0000;
            lk_cnt_ff <= 5'h00;
            lk_tgl_ff <= 1'b0;
        end else begin
            lk_shift_ff <= nxt_lk_shift;
            lk_rx_ff <= nxt_lk_rx;
            lk_cnt_ff <= nxt_lk_cnt;
            lk_tgl_ff <= nxt_lk_tgl;
        end
    end

    // Change edge of the slave clock drives the next output bit
    always_ff @(negedge lk_clk or posedge sys_rst) begin
        if (sys_rst)
            lk_sdo_ff <= 1'b0;
        else
            lk_sdo_ff <= word_msb(lk_src, cfg.w16);
    end

    assign reg_rdata = rdata_ff;
    assign shift_clock_pin_o = sck_ff;
    assign shift_clock_pin_oe = sck_oe_ff;
    assign serial_out_pin_o = cfg.mst ? msdo_ff : lk_sdo_ff;
    assign serial_out_pin_oe = sdo_oe_ff;
    assign slave_select_n_o = fsync_ff ~^ cfg.fpol;
    assign slave_select_n_oe = ss_oe_ff;
endmodule : sspm_core
`default_nettype wire

// File: dv/sspm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sspm_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pin enables
    input wire logic shift_clock_pin_oe,
    input wire logic serial_out_pin_oe
);
    logic [15:0] st_ff, c1_ff, c2_ff;
    logic [15:0] nxt_st, nxt_c1, nxt_c2;
    logic wr_ok, sck_ok, sdo_ok;
    assign wr_ok = reg_wr && clk_en;
    assign sck_ok = st_ff[15] && c1_ff[5];
    assign sdo_ok = st_ff[15] && !c1_ff[11];
    // Shadow of the writable control bits
    always_comb begin
        nxt_st = st_ff;
        nxt_c1 = c1_ff;
        nxt_c2 = c2_ff;
        if (wr_ok && reg_addr == 2'h0) nxt_st = reg_wdata & 16'ha000;
        if (wr_ok && reg_addr == 2'h1) nxt_c1 = reg_wdata & 16'h1fff;
        if (wr_ok && reg_addr == 2'h2) nxt_c2 = reg_wdata & 16'he002;
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= 16'h0000;
            c1_ff <= 16'h0000;
            c2_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            c1_ff <= nxt_c1;
            c2_ff <= nxt_c2;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    rdata_rest_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    stat_read_a: assert property (
        reg_rd && reg_addr == 2'h0 |=> (reg_rdata & 16'hffbc) == st_ff)
        else $error("status control bits read back wrong");
    ctl_one_a: assert property (
        reg_rd && reg_addr == 2'h1 |=> reg_rdata == c1_ff)
        else $error("control one read back wrong");
    ctl_two_a: assert property (
        reg_rd && reg_addr == 2'h2 |=> reg_rdata == c2_ff)
        else $error("control two read back wrong");
    byte_upper_a: assert property (
        reg_rd && reg_addr == 2'h3 && !c1_ff[10] |=> reg_rdata[15:8] == 8'h00)
        else $error("upper byte set in byte mode");
    rbf_clear_a: assert property (
        reg_rd && reg_addr == 2'h3 ##[1:2] reg_rd && reg_addr == 2'h0
        |=> !reg_rdata[0]) else $error("receive full kept after read");
    sck_drive_a: assert property (
        shift_clock_pin_oe |-> $past(sck_ok) || $past(sck_ok, 2))
        else $error("shift clock driven outside enabled master");
    sdo_drive_a: assert property (
        serial_out_pin_oe |-> $past(sdo_ok) || $past(sdo_ok, 2))
        else $error("serial out driven while disabled");
    sdo_held_a: assert property (
        sdo_ok && $past(sdo_ok) && $past(sdo_ok, 2) |-> serial_out_pin_oe)
        else $error("serial out not driven while enabled");
    ovf_seen_c: cover property (reg_rd && reg_addr == 2'h0 ##1 reg_rdata[6]);
    rbf_seen_c: cover property (reg_rd && reg_addr == 2'h0 ##1 reg_rdata[0]);
    sck_on_c: cover property (shift_clock_pin_oe);
endmodule : sspm_chk
bind sspm_core sspm_chk sspm_chk_i (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shift_clock_pin_oe(shift_clock_pin_oe),
    .serial_out_pin_oe(serial_out_pin_oe)
);
`default_nettype wire

// File: dv/sspm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sspm_peer (
    // Line levels seen, with the clock polarity and word width settings
    input wire logic sck,
    input wire logic sdo,
    input wire logic clock_polarity,
    input wire logic w16,
    // Lines driven back
    output logic sdi,
    output logic sck_gen,
    output logic ss_n
);
    logic [15:0] tx_sh = 16'h0000;
    logic [15:0] rx_sh = 16'h0000;
    initial sck_gen = 1'b0;
    initial ss_n = 1'b1;
    // Sample going active, shift going idle
    always @(sck) begin
        if (sck === clock_polarity) tx_sh = tx_sh << 1;
        else rx_sh = {rx_sh[14:0], sdo};
    end
    assign sdi = w16 ? tx_sh[15] : tx_sh[7];
    // Link clock runs only while ss_n holds sel_n, which may leave the select line high
    task automatic frame(input int n, input logic sel_n);
        ss_n = sel_n;
        #45;
        repeat (2 * n) begin
            sck_gen = ~sck_gen;
            #15;
        end
        #30;
        ss_n = 1'b1;
    endtask : frame
endmodule : sspm_peer
`default_nettype wire

// File: dv/sspm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sspm_core_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic idle_mode = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic sck_o, sck_oe, sdo_o, sdo_oe, ss_o, ss_oe;
    logic p_sdi, p_sck, p_ss_n, sck_w, sdo_w, ss_w;
    logic p_ckp = 1'b0;
    logic p_w16 = 1'b0;
    int n_fail = 0;
    int checks_done = 0;
    assign sck_w = sck_oe ? sck_o : p_sck;
    assign sdo_w = sdo_oe ? sdo_o : 1'b1;
    assign ss_w = ss_oe ? ss_o : p_ss_n;
    always #4 clock = ~clock;
    sspm_core sspm_core_i (
        .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .idle_mode(idle_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
        .shift_clock_pin_oe(sck_oe), .serial_in_pin(p_sdi),
        .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe),
        .slave_select_n_i(ss_w), .slave_select_n_o(ss_o),
        .slave_select_n_oe(ss_oe)
    );
    sspm_peer sspm_peer_i (
        .sck(sck_w), .sdo(sdo_w), .clock_polarity(p_ckp), .w16(p_w16),
        .sdi(p_sdi), .sck_gen(p_sck), .ss_n(p_ss_n)
    );
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] q);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        q = reg_rdata;
    endtask : rd
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic poll(input int idx, output logic [15:0] st);
        st = 16'h0000;
        for (int k = 0; k < 400 && st[idx] !== 1'b1; k++) rd(2'h0, st);
    endtask : poll
    task automatic t_regs();
        logic [15:0] d;
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0], d);
            chk(d, 16'h0000);
        end
        wr(2'h1, 16'hfe7e);
        wr(2'h2, 16'hfffe);
        wr(2'h0, 16'hffff);
        rd(2'h1, d);
        chk(d, 16'h1e7e);
        rd(2'h2, d);
        chk(d, 16'he002);
        rd(2'h0, d);
        chk(d, 16'ha000);
        chk({14'h0, sck_oe, sdo_oe}, 16'h0000);
        wr(2'h0, 16'h0000);
        wr(2'h1, 16'h0000);
        wr(2'h2, 16'h0000);
        clk_en <= 1'b0;
        wr(2'h1, 16'h0fff);
        clk_en <= 1'b1;
        rd(2'h1, d);
        chk(d, 16'h0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_master();
        logic [15:0] d;
        wr(2'h1, 16'h013a);
        wr(2'h0, 16'h8000);
        sspm_peer_i.tx_sh = 16'h003c;
        wr(2'h3, 16'h00a5);
        chk({14'h0, sck_oe, sdo_oe}, 16'h0003);
        repeat (10) @(posedge clock);
        wr(2'h3, 16'h005a);
        rd(2'h0, d);
        chk(d, 16'h8002);
        poll(0, d);
        rd(2'h3, d);
        chk(d, 16'h003c);
        poll(0, d);
        chk(sspm_peer_i.rx_sh & 16'h00ff, 16'h005a);
        sspm_peer_i.tx_sh = 16'h00c3;
        wr(2'h3, 16'h00ff);
        poll(6, d);
        rd(2'h3, d);
        chk(d, 16'h0000);
        rd(2'h0, d);
        chk(d, 16'h8040);
        wr(2'h0, 16'h8040);
        rd(2'h0, d);
        chk(d, 16'h8040);
        wr(2'h0, 16'h8000);
        rd(2'h0, d);
        chk(d, 16'h8000);
        wr(2'h0, 16'h0000);
        $display("test master done");
    endtask : t_master
    task automatic t_wide();
        logic [15:0] d;
        p_ckp = 1'b1;
        p_w16 = 1'b1;
        wr(2'h1, 16'h077a);
        wr(2'h0, 16'h8000);
        repeat (4) @(posedge clock);
        chk({15'h0, sck_o}, 16'h0001);
        sspm_peer_i.tx_sh = 16'hbeef;
        wr(2'h3, 16'h1234);
        poll(0, d);
        chk(sspm_peer_i.rx_sh, 16'h1234);
        rd(2'h3, d);
        chk(d, 16'hbeef);
        wr(2'h0, 16'h0000);
        p_ckp = 1'b0;
        p_w16 = 1'b0;
        $display("test wide done");
    endtask : t_wide
    task automatic t_idle();
        logic [15:0] d;
        wr(2'h1, 16'h013a);
        wr(2'h0, 16'ha000);
        idle_mode <= 1'b1;
        wr(2'h3, 16'h0081);
        repeat (300) @(posedge clock);
        rd(2'h0, d);
        chk(d & 16'h0003, 16'h0002);
        idle_mode <= 1'b0;
        poll(0, d);
        chk(d & 16'h0001, 16'h0001);
        rd(2'h3, d);
        wr(2'h0, 16'h8000);
        idle_mode <= 1'b1;
        wr(2'h3, 16'h0042);
        poll(0, d);
        chk(d & 16'h0001, 16'h0001);
        idle_mode <= 1'b0;
        rd(2'h3, d);
        wr(2'h0, 16'h0000);
        $display("test idle done");
    endtask : t_idle
    task automatic t_frame();
        logic [15:0] d;
        logic seen;
        seen = 1'b0;
        wr(2'h1, 16'h003a);
        wr(2'h2, 16'h8000);
        wr(2'h0, 16'h8000);
        wr(2'h3, 16'h0011);
        for (int k = 0; k < 40 && !seen; k++) begin
            @(negedge clock);
            seen = ss_oe && !ss_w;
        end
        chk({15'h0, seen}, 16'h0001);
        poll(0, d);
        chk({14'h0, ss_oe, ss_w}, 16'h0003);
        rd(2'h3, d);
        wr(2'h0, 16'h0000);
        wr(2'h2, 16'h0000);
        $display("test frame done");
    endtask : t_frame
    task automatic t_slave();
        logic [15:0] d;
        wr(2'h1, 16'h0180);
        wr(2'h0, 16'h8000);
        wr(2'h3, 16'h0096);
        sspm_peer_i.frame(8, 1'b1);
        repeat (10) @(posedge clock);
        rd(2'h0, d);
        chk(d & 16'h0001, 16'h0000);
        chk({15'h0, sck_oe}, 16'h0000);
        sspm_peer_i.tx_sh = 16'h0069;
        sspm_peer_i.frame(8, 1'b0);
        poll(0, d);
        rd(2'h3, d);
        chk(d, 16'h0069);
        chk(sspm_peer_i.rx_sh & 16'h00ff, 16'h0096);
        wr(2'h0, 16'h0000);
        $display("test slave done");
    endtask : t_slave
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_master();
        t_wide();
        t_frame();
        t_idle();
        t_slave();
        stop_test();
    end
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
endmodule : sspm_core_tb
`default_nettype wire
